// ---- hw/conv_ctrl_pkg.sv ----
package conv_ctrl_pkg;

  localparam int CODE_W = 14;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;

  typedef logic [CODE_W-1:0] code_type;
  typedef code_type [NUM_CH-1:0] dac_bus_type;

  // byte addresses of the word registers
  localparam logic [7:0] SCAN_LIST_ADDR = 8'h00;
  localparam logic [7:0] LAUNCH_ADDR = 8'h04;
  localparam logic [7:0] RESULT_ADDR = 8'h08;
  localparam logic [7:0] GEN_CTRL_ADDR = 8'h0c;
  localparam logic [7:0] CNT_CTRL_ADDR = 8'h10;
  localparam logic [7:0] LATCH_BASE_ADDR = 8'h20;
  localparam logic [7:0] LATCH_LAST_ADDR = 8'h3c;

  // field positions
  localparam int END_FLAG_BIT = 17;
  localparam int LOAD_HOLD_BIT = 23;
  localparam int CONNECT_BIT = 26;
  localparam int SRC_SEL_BIT = 30;
  localparam int IRQ_SEL_BIT = 31;

  // reset values
  localparam code_type DAC_MID_CODE = 14'h2000;
  localparam logic [NUM_CH-1:0] SCAN_RESET = 8'h00;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CONVERT = 2'b11,
    SEQ_WAIT = 2'b10
  } seq_state_type;

  // command to the analogue converter front end
  typedef struct packed {
    logic sample;
    logic convert;
    logic [CH_W-1:0] channel;
  } adc_cmd_type;

  // answer from the converter
  typedef struct packed {
    logic done;
    code_type data;
  } adc_rsp_type;

endpackage : conv_ctrl_pkg

// ---- hw/result_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module result_fifo
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic flush,
  input wire logic push,
  input wire code_type pushData,
  input wire logic pop,
  // state
  output code_type headData,
  output logic empty
);
  code_type mem [NUM_CH];
  logic [CH_W:0] wrPtr_r;
  logic [CH_W:0] rdPtr_r;

  assign empty = (wrPtr_r == rdPtr_r);
  assign headData = empty ? '0 : mem[rdPtr_r[CH_W-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r[CH_W-1:0]] <= pushData;
    end
  end

  // flush wins over push and pop: a new scan discards everything
  always_ff @(posedge clock) begin
    if (!rst_n || flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push && (wrPtr_r - rdPtr_r) != (CH_W+1)'(NUM_CH)) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop && !empty) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule : result_fifo
`default_nettype wire

// ---- hw/dac_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
module dac_channel
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // latch write and load control
  input wire logic write,
  input wire code_type writeData,
  input wire logic loadHold,
  // contents
  output code_type latchCode,
  output code_type dacCode
);
  code_type latch_r;
  code_type dac_r;
  code_type latch_nxt;

  assign latch_nxt = write ? writeData : latch_r;
  assign latchCode = latch_r;
  assign dacCode = dac_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latch_r <= DAC_MID_CODE;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // hold released: every channel copies its latch on the same edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dac_r <= DAC_MID_CODE;
    end else if (!loadHold) begin
      dac_r <= latch_nxt;
    end
  end
endmodule : dac_channel
`default_nettype wire

// ---- hw/adc_dac_conversion_control.sv ----
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module adc_dac_conversion_control
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // trigger sources
  input wire logic timerPulse,
  input wire logic extTrigger,
  // analogue input converter
  output adc_cmd_type adcCmd,
  input wire adc_rsp_type adcRsp,
  // analogue output converters
  output dac_bus_type dacCodes,
  output logic dacConnect,
  // interrupt request line to the card
  output logic cardIrq
);

  // register state
  logic [NUM_CH-1:0] scanList_r;
  logic loadHold_r;
  logic connect_r;
  logic srcSel_r;
  logic irqSel_r;
  logic endFlag_r;

  // bus phase tracking
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic [31:0] rdValue;

  // conversion sequencer
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [NUM_CH-1:0] pending_r;
  logic [CH_W-1:0] chan_r;
  adc_cmd_type adcCmd_r;
  logic hwSrc_r;
  logic hwSrcNow;
  logic irqNow;
  logic cardIrq_r;

  // fifo and output converters
  logic fifoPush;
  logic fifoPop;
  code_type fifoHead;
  logic fifoEmpty;
  dac_bus_type latchCodes;
  dac_bus_type dacCodesInt;
  dac_bus_type dacCodes_r;
  logic dacConnect_r;

  logic addrPhase;
  logic rdAccess;
  logic wrAccess;
  logic launchRead;
  logic hwStart;
  logic startConv;
  logic [NUM_CH-1:0] latchWrite;
  logic [CH_W-1:0] nextChan;
  logic anyPending;

  // bus decode
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rdAccess = addrPhase && !hwrite;
  assign wrAccess = addrPhase && hwrite;
  // only whole words are meaningful; narrower sizes act on the same word when addressed at its first byte
  assign launchRead = rdAccess && haddr[7:0] == LAUNCH_ADDR && haddr[31:8] == '0;
  assign fifoPop = rdAccess && haddr[7:0] == RESULT_ADDR && haddr[31:8] == '0;

  // hardware trigger: rising edge of the selected source
  assign hwSrcNow = srcSel_r ? extTrigger : timerPulse;
  assign hwStart = hwSrcNow && !hwSrc_r;
  assign startConv = launchRead || hwStart;

  assign irqNow = irqSel_r ? extTrigger : timerPulse;

  // ascending channel order: lowest pending bit first
  always_comb begin
    nextChan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending_r[i]) begin
        nextChan = CH_W'(i);
      end
    end
  end
  assign anyPending = |pending_r;

  // read mux, sampled in the address phase
  always_comb begin
    rdValue = '0;
    if (haddr[31:8] == '0) begin
      unique case (haddr[7:0])
        SCAN_LIST_ADDR: rdValue[NUM_CH-1:0] = scanList_r;
        RESULT_ADDR: rdValue[CODE_W-1:0] = fifoEmpty ? '0 : fifoHead;
        GEN_CTRL_ADDR: begin
          rdValue[END_FLAG_BIT] = endFlag_r;
          rdValue[LOAD_HOLD_BIT] = loadHold_r;
          rdValue[CONNECT_BIT] = connect_r;
        end
        CNT_CTRL_ADDR: begin
          rdValue[SRC_SEL_BIT] = srcSel_r;
          rdValue[IRQ_SEL_BIT] = irqSel_r;
        end
        default: begin
          if (haddr[7:0] >= LATCH_BASE_ADDR && haddr[7:0] <= LATCH_LAST_ADDR &&
              haddr[1:0] == 2'b00) begin
            rdValue[CODE_W-1:0] = latchCodes[haddr[4:2]];
          end
        end
      endcase
    end
  end

  // zero wait states; every answer OKAY
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata_r <= '0;
    end else if (rdAccess) begin
      hrdata_r <= rdValue;
    end
  end

  // write address held for the data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end else if (hready) begin
      wrPend_r <= wrAccess && haddr[31:8] == '0;
      wrAddr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scanList_r <= SCAN_RESET;
    end else if (wrPend_r && wrAddr_r == SCAN_LIST_ADDR) begin
      scanList_r <= hwdata[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loadHold_r <= 1'b0;
      connect_r <= 1'b0;
    end else if (wrPend_r && wrAddr_r == GEN_CTRL_ADDR) begin
      loadHold_r <= hwdata[LOAD_HOLD_BIT];
      connect_r <= hwdata[CONNECT_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      srcSel_r <= 1'b0;
      irqSel_r <= 1'b0;
    end else if (wrPend_r && wrAddr_r == CNT_CTRL_ADDR) begin
      srcSel_r <= hwdata[SRC_SEL_BIT];
      irqSel_r <= hwdata[IRQ_SEL_BIT];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      latchWrite[i] = wrPend_r && wrAddr_r == (LATCH_BASE_ADDR + 8'(4 * i));
    end
  end

  // trigger edge history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hwSrc_r <= 1'b0;
    end else begin
      hwSrc_r <= hwSrcNow;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cardIrq_r <= 1'b0;
    end else begin
      cardIrq_r <= irqNow;
    end
  end

  // sequencer next state; a start in any state restarts the scan
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SEQ_IDLE: state_nxt = SEQ_IDLE;
      SEQ_SAMPLE: state_nxt = anyPending ? SEQ_CONVERT : SEQ_IDLE;
      SEQ_CONVERT: state_nxt = SEQ_WAIT;
      SEQ_WAIT: begin
        if (adcRsp.done) begin
          state_nxt = anyPending ? SEQ_CONVERT : SEQ_IDLE;
        end
      end
    endcase
    if (startConv) begin
      state_nxt = SEQ_SAMPLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SEQ_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // channels still to convert in this scan
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pending_r <= '0;
      chan_r <= '0;
    end else if (startConv) begin
      pending_r <= scanList_r;
      chan_r <= '0;
    end else if ((state_r == SEQ_SAMPLE || state_r == SEQ_WAIT && adcRsp.done) && anyPending) begin
      chan_r <= nextChan;
      pending_r[nextChan] <= 1'b0;
    end
  end

  // one sample strobe freezes all inputs together, then one convert per channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adcCmd_r <= '0;
    end else begin
      adcCmd_r.sample <= startConv;
      adcCmd_r.convert <= state_nxt == SEQ_CONVERT && !startConv;
      adcCmd_r.channel <= (state_nxt == SEQ_CONVERT) ? nextChan : chan_r;
    end
  end

  // results arriving after a restart belong to the discarded scan
  assign fifoPush = state_r == SEQ_WAIT && adcRsp.done && !startConv;

  // start wins over completion in the same cycle: flag goes high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      endFlag_r <= 1'b1;
    end else if (startConv) begin
      endFlag_r <= 1'b1;
    end else if (state_r != SEQ_IDLE && state_nxt == SEQ_IDLE) begin
      endFlag_r <= 1'b0;
    end
  end

  result_fifo u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(startConv),
    .push(fifoPush),
    .pushData(adcRsp.data),
    .pop(fifoPop),
    .headData(fifoHead),
    .empty(fifoEmpty)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_dac
      dac_channel u_dac (
        .clock(clock),
        .rst_n(rst_n),
        .write(latchWrite[g]),
        .writeData(hwdata[CODE_W-1:0]),
        .loadHold(loadHold_r),
        .latchCode(latchCodes[g]),
        .dacCode(dacCodesInt[g])
      );
    end
  endgenerate

  // registered copy keeps every converter on the same edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dacCodes_r <= {NUM_CH{DAC_MID_CODE}};
      dacConnect_r <= 1'b0;
    end else begin
      dacCodes_r <= dacCodesInt;
      dacConnect_r <= connect_r;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign adcCmd = adcCmd_r;
  assign dacCodes = dacCodes_r;
  assign dacConnect = dacConnect_r;
  assign cardIrq = cardIrq_r;

endmodule : adc_dac_conversion_control
`default_nettype wire

// ---- sim/adc_dac_conversion_control_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_dac_conversion_control_props
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // converters and triggers
  input wire logic timerPulse,
  input wire logic extTrigger,
  input wire adc_cmd_type adcCmd,
  input wire adc_rsp_type adcRsp,
  input wire dac_bus_type dacCodes,
  input wire logic dacConnect,
  input wire logic cardIrq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic busRd;
  logic busWr;
  assign busRd = hsel && hready && htrans[1] && !hwrite;
  assign busWr = hsel && hready && htrans[1] && hwrite;
  launch_start_a: assert property (busRd && haddr == {24'h0, LAUNCH_ADDR}
    |=> adcCmd.sample && hrdata == 32'h0) else $error("launch read gave no sample");
  sample_pulse_a: assert property (adcCmd.sample
    |-> !adcCmd.convert ##1 !adcCmd.sample) else $error("sample not a lone pulse");
  convert_pulse_a: assert property (adcCmd.convert |=> !adcCmd.convert)
    else $error("convert longer than one cycle");
  dac_reset_a: assert property (disable iff (1'b0) !rst_n
    |=> dacCodes == {NUM_CH{DAC_MID_CODE}} && !dacConnect) else $error("reset state wrong");
  dac_cause_a: assert property ($changed(dacCodes)
    |-> $past(busWr, 3) || $past(busWr, 4)) else $error("dac code moved without a write");
  connect_follow_a: assert property (busWr && haddr == {24'h0, GEN_CTRL_ADDR}
    |-> ##3 dacConnect == $past(hwdata[CONNECT_BIT], 2)) else $error("connect wrong");
  irq_source_a: assert property (cardIrq == $past(timerPulse)
    || cardIrq == $past(extTrigger)) else $error("irq from no source");
  upper_zero_a: assert property (busRd && (haddr[7:0] == RESULT_ADDR
    || haddr[7:0] >= LATCH_BASE_ADDR) |=> hrdata[31:CODE_W] == '0)
    else $error("upper data bits set");
  cover property (adcCmd.sample ##1 adcCmd.convert);
  cover property (adcRsp.done);
  cover property ($fell(dacConnect));
endmodule : adc_dac_conversion_control_props
bind adc_dac_conversion_control adc_dac_conversion_control_props u_props (.clock(clock),
  .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .timerPulse(timerPulse), .extTrigger(extTrigger), .adcCmd(adcCmd), .adcRsp(adcRsp),
  .dacCodes(dacCodes), .dacConnect(dacConnect), .cardIrq(cardIrq));
`default_nettype wire

// ---- sim/adc_dac_conversion_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_dac_conversion_control_bench;
  import conv_ctrl_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, timerPulse = 0, extTrigger = 0;
  logic hreadyout, hresp, dacConnect, cardIrq, seen;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  adc_cmd_type adcCmd;
  adc_rsp_type adcRsp = '0;
  dac_bus_type dacCodes;
  code_type adcTable [NUM_CH] = '{14'h2000, 14'h1fff, 14'h3fff, 14'h0000, 14'h0123, 14'h2abc,
    14'h1555, 14'h3001};
  int errors = 0, tests_run = 0;
  always #5 clock = ~clock;
  adc_dac_conversion_control u_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timerPulse(timerPulse),
    .extTrigger(extTrigger), .adcCmd(adcCmd), .adcRsp(adcRsp), .dacCodes(dacCodes),
    .dacConnect(dacConnect), .cardIrq(cardIrq));
  // converter answers one cycle after convert; data line toggles when idle
  always @(posedge clock) begin
    adcRsp.done <= adcCmd.convert;
    adcRsp.data <= adcCmd.convert ? adcTable[adcCmd.channel] : ~adcRsp.data;
  end
  function automatic code_type cv(input int i, input logic inv);
    cv = 14'(i * 14'h0801) ^ {14{inv}};
  endfunction : cv
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask : bus
  task automatic wait_done;
    for (int n = 0; n < 60; n++) begin
      bus(0, GEN_CTRL_ADDR, 0);
      if (rd[END_FLAG_BIT] === 1'b0) break;
    end
    `CHK("end flag", 1'b0, rd[END_FLAG_BIT])
  endtask : wait_done
  task automatic t_reset;
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK("dac", DAC_MID_CODE, dacCodes[i])
      bus(0, LATCH_BASE_ADDR + 8'(4 * i), 0);
      `CHK("latch", 32'h2000, rd)
    end
    `CHK("connect", 1'b0, dacConnect)
    bus(0, GEN_CTRL_ADDR, 0);
    `CHK("end flag", 1'b1, rd[END_FLAG_BIT])
    bus(0, 8'h44, 0);
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset
  task automatic t_scan;
    bus(1, SCAN_LIST_ADDR, 32'h8d);
    bus(0, SCAN_LIST_ADDR, 0);
    `CHK("scan", 32'h8d, rd)
    bus(0, LAUNCH_ADDR, 0);
    wait_done();
    bus(0, RESULT_ADDR, 0);
    `CHK("result", {18'h0, adcTable[0]}, rd)
    // three entries left unread, the next start must drop them
    bus(0, GEN_CTRL_ADDR, 0);
    `CHK("end flag", 1'b0, rd[END_FLAG_BIT])
    bus(1, SCAN_LIST_ADDR, 32'hff);
    bus(0, LAUNCH_ADDR, 0);
    bus(0, GEN_CTRL_ADDR, 0);
    `CHK("end flag", 1'b1, rd[END_FLAG_BIT])
    wait_done();
    for (int i = 0; i < NUM_CH; i++) begin
      bus(0, RESULT_ADDR, 0);
      `CHK("result", {18'h0, adcTable[i]}, rd)
    end
    bus(0, RESULT_ADDR, 0);
    `CHK("empty", 32'h0, rd)
  endtask : t_scan
  task automatic pulse(input logic ext, input logic expSample, input logic expIrq);
    seen = 0;
    @(posedge clock);
    if (ext) extTrigger <= 1;
    else timerPulse <= 1;
    repeat (6) begin
      @(posedge clock);
      seen = seen | adcCmd.sample;
    end
    `CHK("irq", expIrq, cardIrq)
    `CHK("trigger", expSample, seen)
    extTrigger <= 0;
    timerPulse <= 0;
    repeat (40) @(posedge clock);
  endtask : pulse
  task automatic t_external_conversion_pulse_input;
    bus(1, CNT_CTRL_ADDR, 0);
    pulse(0, 1, 1);
    pulse(1, 0, 0);
    bus(1, CNT_CTRL_ADDR, 32'hc000_0000);
    pulse(1, 1, 1);
    pulse(0, 0, 0);
    bus(1, CNT_CTRL_ADDR, 32'h4000_0000);
    pulse(0, 0, 1);
  endtask : t_external_conversion_pulse_input
  task automatic t_dac;
    bus(1, GEN_CTRL_ADDR, 32'h0400_0000);
    repeat (2) @(posedge clock);
    `CHK("connect", 1'b1, dacConnect)
    for (int i = 0; i < NUM_CH; i++) bus(1, LATCH_BASE_ADDR + 8'(4 * i), {18'h0, cv(i, 0)});
    repeat (3) @(posedge clock);
    for (int i = 0; i < NUM_CH; i++) `CHK("dac", cv(i, 0), dacCodes[i])
    bus(1, GEN_CTRL_ADDR, 32'h0480_0000);
    for (int i = 0; i < NUM_CH; i++) bus(1, LATCH_BASE_ADDR + 8'(4 * i), {18'h0, cv(i, 1)});
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK("held", cv(i, 0), dacCodes[i])
      bus(0, LATCH_BASE_ADDR + 8'(4 * i), 0);
      `CHK("latch", {18'h0, cv(i, 1)}, rd)
    end
    bus(1, GEN_CTRL_ADDR, 0);
    repeat (3) @(posedge clock);
    for (int i = 0; i < NUM_CH; i++) `CHK("load", cv(i, 1), dacCodes[i])
    `CHK("connect", 1'b0, dacConnect)
  endtask : t_dac
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // limit well above the few hundred cycles the tasks need
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    t_reset();
    t_scan();
    t_external_conversion_pulse_input();
    t_dac();
    stop_test();
  end
endmodule : adc_dac_conversion_control_bench
`default_nettype wire
